// ==== verilog/hpsc_bank.sv ====
/*
 * Host port switch control register bank with AXI4-Lite slave and per-frame
 * policy decisions (receive gate, learning, sniffing, priority ceiling, VLAN mask).
 * Assumes frame requests arrive one cycle wide, synchronous to aclk.
 */
`timescale 1ns/1ps

module hpsc_bank #(
	parameter int DATA_W = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [hpsc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [DATA_W/8-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [hpsc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire hpsc_pkg::hpsc_frame_t rx_frame,
	input wire logic [2:0] default_prio,
	input wire logic tx_frame,
	output hpsc_pkg::hpsc_frame_t fwd_r,
	output logic learn_r,
	output logic rx_mon_r,
	output logic tx_go_r,
	output logic tx_mon_r,
	output hpsc_pkg::hpsc_ctrl_t ctrl_r
);
	// ==========================================================
	// Register storage
	// ==========================================================
	logic [15:0] control_two_r;
	logic [15:0] host_port_vid_control_r;
	logic [15:0] host_port_control_three_r;
	logic [15:0] host_port_ingress_rate_r;
	logic [15:0] host_port_egress_rate_r;
	logic [7:0] bank_r;
	logic aw_hold_r;
	logic w_hold_r;
	logic [hpsc_pkg::ADDR_W-1:0] awaddr_r;
	logic [DATA_W-1:0] wdata_r;
	logic [DATA_W/8-1:0] wstrb_r;
	logic [4:0] wsel_idx;
	logic [4:0] rsel_idx;
	logic [15:0] rsel;
	logic rhit;
	logic whit;
	logic [3:0] widx;
	logic do_write;

	// Byte address to register index; misaligned addresses give no index.
	function automatic logic [4:0] to_idx(input logic [hpsc_pkg::ADDR_W-1:0] a);
		to_idx = (a[1:0] == 2'b00) ? {1'b0, a[5:2]} : 5'h10;
	endfunction : to_idx

	// Decode: bank select in every bank, host port registers only in their own bank.
	function automatic logic hit(input logic [4:0] i, input logic [7:0] bank);
		logic host;
		host = (bank == hpsc_pkg::BANK_HOST_PORT);
		hit = 1'b0;
		if (i[4] == 1'b0) begin
			if (i[3:0] == hpsc_pkg::IDX_BANK_SELECT) begin
				hit = 1'b1;
			end else if (host) begin
				hit = (i[3:0] == hpsc_pkg::IDX_CONTROL_TWO)
					|| (i[3:0] == hpsc_pkg::IDX_VID_CONTROL)
					|| (i[3:0] == hpsc_pkg::IDX_CONTROL_THREE)
					|| (i[3:0] == hpsc_pkg::IDX_INGRESS_RATE)
					|| (i[3:0] == hpsc_pkg::IDX_EGRESS_RATE);
			end
		end
	endfunction : hit

	// ==========================================================
	// Write channel
	// ==========================================================
	assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
	assign wsel_idx = to_idx(awaddr_r);
	assign widx = wsel_idx[3:0];
	assign whit = hit(wsel_idx, bank_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= hpsc_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_hold_r && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !w_hold_r && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= whit ? hpsc_pkg::RESP_OKAY : hpsc_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			control_two_r <= hpsc_pkg::CONTROL_TWO_RESET;
			host_port_vid_control_r <= hpsc_pkg::REG16_RESET;
			host_port_control_three_r <= hpsc_pkg::REG16_RESET;
			host_port_ingress_rate_r <= hpsc_pkg::REG16_RESET;
			host_port_egress_rate_r <= hpsc_pkg::REG16_RESET;
			bank_r <= hpsc_pkg::BANK_RESET;
		end else if (do_write && whit) begin
			unique case (widx)
				hpsc_pkg::IDX_CONTROL_TWO: begin
					control_two_r <= (merge(control_two_r, wdata_r, wstrb_r)
						& hpsc_pkg::CONTROL_TWO_WMASK)
						| (control_two_r & ~hpsc_pkg::CONTROL_TWO_WMASK);
				end
				hpsc_pkg::IDX_VID_CONTROL: begin
					host_port_vid_control_r <= merge(host_port_vid_control_r, wdata_r,
						wstrb_r);
				end
				hpsc_pkg::IDX_CONTROL_THREE: begin
					host_port_control_three_r <= merge(host_port_control_three_r,
						wdata_r, wstrb_r);
				end
				hpsc_pkg::IDX_INGRESS_RATE: begin
					host_port_ingress_rate_r <= merge(host_port_ingress_rate_r,
						wdata_r, wstrb_r);
				end
				hpsc_pkg::IDX_EGRESS_RATE: begin
					host_port_egress_rate_r <= merge(host_port_egress_rate_r,
						wdata_r, wstrb_r);
				end
				hpsc_pkg::IDX_BANK_SELECT: begin
					if (wstrb_r[0]) begin
						bank_r <= wdata_r[7:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Read channel
	// ==========================================================
	assign rsel_idx = to_idx(s_axi_araddr);
	assign rhit = hit(rsel_idx, bank_r);

	always_comb begin
		rsel = 16'h0000;
		unique case (rsel_idx[3:0])
			hpsc_pkg::IDX_CONTROL_TWO: rsel = control_two_r;
			hpsc_pkg::IDX_VID_CONTROL: rsel = host_port_vid_control_r;
			hpsc_pkg::IDX_CONTROL_THREE: rsel = host_port_control_three_r;
			hpsc_pkg::IDX_INGRESS_RATE: rsel = host_port_ingress_rate_r;
			hpsc_pkg::IDX_EGRESS_RATE: rsel = host_port_egress_rate_r;
			hpsc_pkg::IDX_BANK_SELECT: rsel = {8'h00, bank_r};
			default: rsel = 16'h0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= hpsc_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rhit ? {{(DATA_W-16){1'b0}}, rsel} : '0;
				s_axi_rresp <= rhit ? hpsc_pkg::RESP_OKAY : hpsc_pkg::RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Frame policy
	// ==========================================================
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fwd_r <= '0;
			learn_r <= 1'b0;
			rx_mon_r <= 1'b0;
			tx_go_r <= 1'b0;
			tx_mon_r <= 1'b0;
			ctrl_r <= '0;
		end else begin
			ctrl_r <= {control_two_r[hpsc_pkg::BIT_TX_EN:hpsc_pkg::BIT_TX_SNIFF],
				control_two_r[hpsc_pkg::BIT_PRIO_CEIL:0]};
			fwd_r.valid <= rx_frame.valid && control_two_r[hpsc_pkg::BIT_RX_EN];
			fwd_r.dest <= rx_frame.dest & control_two_r[hpsc_pkg::MEMBER_W-1:0];
			fwd_r.prio <= (control_two_r[hpsc_pkg::BIT_PRIO_CEIL]
				&& rx_frame.prio > default_prio) ? default_prio : rx_frame.prio;
			learn_r <= rx_frame.valid && control_two_r[hpsc_pkg::BIT_RX_EN]
				&& !control_two_r[hpsc_pkg::BIT_LEARN_DIS];
			rx_mon_r <= rx_frame.valid && control_two_r[hpsc_pkg::BIT_RX_EN]
				&& control_two_r[hpsc_pkg::BIT_RX_SNIFF];
			tx_go_r <= tx_frame && control_two_r[hpsc_pkg::BIT_TX_EN];
			tx_mon_r <= tx_frame && control_two_r[hpsc_pkg::BIT_TX_EN]
				&& control_two_r[hpsc_pkg::BIT_TX_SNIFF];
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Frame policy decisions, one cycle after the request.
	AST_RX_GATE: assert property (fwd_r.valid |-> $past(control_two_r[9]))
		else $error("Frame accepted while receive disabled.");
	AST_RX_BLOCK: assert property (rx_frame.valid && !control_two_r[9]
		|=> !fwd_r.valid && !learn_r && !rx_mon_r)
		else $error("Refused frame still produced a decision.");
	AST_LEARN: assert property (learn_r |-> !$past(control_two_r[8]))
		else $error("Learning while learning disabled.");
	AST_LEARN_ON: assert property (rx_frame.valid && control_two_r[9]
		&& !control_two_r[8] |=> learn_r)
		else $error("Accepted frame not offered for learning.");
	AST_SNIFFER: assert property (ctrl_r.sniffer_port == $past(control_two_r[7]))
		else $error("Sniffer designation not passed on.");
	AST_RX_MON: assert property (rx_frame.valid && control_two_r[9]
		&& control_two_r[6] |=> rx_mon_r)
		else $error("Received frame not marked monitored.");
	AST_RX_SNIFF_OFF: assert property (rx_frame.valid && !control_two_r[6]
		|=> !rx_mon_r)
		else $error("Received frame marked without receive sniff.");
	AST_TX_MON: assert property (tx_mon_r |-> tx_go_r && $past(control_two_r[5]))
		else $error("Transmit monitor without transmit sniff.");
	AST_TX_SNIFF_ON: assert property (tx_frame && control_two_r[10]
		&& control_two_r[5] |=> tx_mon_r)
		else $error("Transmitted frame not marked monitored.");
	AST_CEIL: assert property (fwd_r.valid && $past(control_two_r[3])
		|-> fwd_r.prio <= $past(default_prio))
		else $error("Priority above ceiling.");
	AST_CEIL_OFF: assert property (rx_frame.valid && !control_two_r[3]
		|=> fwd_r.prio == $past(rx_frame.prio))
		else $error("Priority changed with ceiling off.");
	AST_MEMBER_HOST: assert property (rx_frame.valid && control_two_r[9]
		&& control_two_r[2] && rx_frame.dest[2] |=> fwd_r.valid && fwd_r.dest[2])
		else $error("Frame not forwarded to included host port.");
	AST_MEMBER: assert property ((fwd_r.dest & ~$past(control_two_r[2:0])) == 3'h0)
		else $error("Frame forwarded to excluded port.");
	AST_TX_GATE: assert property (tx_frame && !control_two_r[10] |=> !tx_go_r)
		else $error("Transmission while transmit disabled.");
	AST_TX_GO: assert property (tx_frame && control_two_r[10] |=> tx_go_r)
		else $error("Permitted transmission not passed on.");

	// Register access and bank gating.
	AST_RESET_VALUE: assert property ($rose(aresetn)
		|-> control_two_r == 16'h0607 && bank_r == 8'h00)
		else $error("Control two or bank select not at reset value.");
	AST_HOST_READ: assert property (s_axi_arvalid && s_axi_arready
		&& bank_r == 8'h34 && s_axi_araddr == 6'h08
		|=> s_axi_rresp == 2'h0 && s_axi_rdata[15:0] == $past(control_two_r))
		else $error("Control two not readable in host port bank.");
	AST_VID_WRITE: assert property (do_write && bank_r == 8'h34
		&& awaddr_r == 6'h10 && wstrb_r[1:0] == 2'h3
		|=> host_port_vid_control_r == $past(wdata_r[15:0]) && s_axi_bresp == 2'h0)
		else $error("VID control write did not land.");
	AST_THREE_WRITE: assert property (do_write && bank_r == 8'h34
		&& awaddr_r == 6'h18 && wstrb_r[1:0] == 2'h3
		|=> host_port_control_three_r == $past(wdata_r[15:0]) && s_axi_bresp == 2'h0)
		else $error("Control three write did not land.");
	AST_INGRESS_WRITE: assert property (do_write && bank_r == 8'h34
		&& awaddr_r == 6'h20 && wstrb_r[1:0] == 2'h3
		|=> host_port_ingress_rate_r == $past(wdata_r[15:0]) && s_axi_bresp == 2'h0)
		else $error("Ingress rate write did not land.");
	AST_EGRESS_WRITE: assert property (do_write && bank_r == 8'h34
		&& awaddr_r == 6'h28 && wstrb_r[1:0] == 2'h3
		|=> host_port_egress_rate_r == $past(wdata_r[15:0]) && s_axi_bresp == 2'h0)
		else $error("Egress rate write did not land.");
	AST_RSVD_BANK: assert property (s_axi_arvalid && s_axi_arready
		&& bank_r != 8'h34 && s_axi_araddr != 6'h38
		|=> s_axi_rvalid && s_axi_rresp == 2'h2)
		else $error("Reserved bank access not refused.");
	AST_RSVD_WRITE: assert property (do_write && bank_r != 8'h34
		&& awaddr_r != 6'h38
		|=> s_axi_bresp == 2'h2 && $stable(control_two_r) && $stable(bank_r))
		else $error("Reserved bank write not refused.");
	AST_BANK_SEL: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == 6'h38
		|=> s_axi_rresp == 2'h0 && s_axi_rdata[7:0] == $past(bank_r))
		else $error("Bank select not readable.");
	AST_BANK_WRITE: assert property (do_write && awaddr_r == 6'h38 && wstrb_r[0]
		|=> bank_r == $past(wdata_r[7:0]) && s_axi_bresp == 2'h0)
		else $error("Bank select write did not land.");

	COV_WRITE: cover property (s_axi_bvalid && s_axi_bresp == 2'h0);
	COV_READ: cover property (s_axi_rvalid && s_axi_rresp == 2'h0);
	COV_RSVD: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	COV_FWD: cover property (fwd_r.valid && rx_mon_r);
	COV_TX: cover property (tx_mon_r);
endmodule : hpsc_bank

// ==== shared/hpsc_pkg.sv ====
/*
 * Constants and carrier types for the host port switch control bank.
 * Assumes an AXI4-Lite master with 32-bit data; one register per aligned word.
 */
package hpsc_pkg;
	// ==========================================================
	// Register indices and byte addresses
	// ==========================================================
	// Offsets 0x02..0x0E are not all multiples of four, so they are indices.
	localparam logic [3:0] IDX_CONTROL_TWO = 4'h2;
	localparam logic [3:0] IDX_VID_CONTROL = 4'h4;
	localparam logic [3:0] IDX_CONTROL_THREE = 4'h6;
	localparam logic [3:0] IDX_INGRESS_RATE = 4'h8;
	localparam logic [3:0] IDX_EGRESS_RATE = 4'hA;
	localparam logic [3:0] IDX_BANK_SELECT = 4'hE;
	localparam logic [5:0] IDX_TO_BYTE_SHIFT = 6'h02;
	localparam int ADDR_W = 6;

	// ==========================================================
	// Banks
	// ==========================================================
	localparam logic [7:0] BANK_HOST_PORT = 8'h34;
	localparam logic [7:0] BANK_RSVD_FIRST = 8'h35;
	localparam logic [7:0] BANK_RSVD_LAST = 8'h3F;
	localparam logic [7:0] BANK_RESET = 8'h00;

	// ==========================================================
	// Control-two fields
	// ==========================================================
	localparam int BIT_TX_EN = 10;
	localparam int BIT_RX_EN = 9;
	localparam int BIT_LEARN_DIS = 8;
	localparam int BIT_SNIFFER = 7;
	localparam int BIT_RX_SNIFF = 6;
	localparam int BIT_TX_SNIFF = 5;
	localparam int BIT_PRIO_CEIL = 3;
	localparam int MEMBER_W = 3;
	localparam logic [15:0] CONTROL_TWO_RESET = 16'h0607;
	localparam logic [15:0] CONTROL_TWO_WMASK = 16'h67FF;
	localparam logic [15:0] REG16_RESET = 16'h0000;

	// ==========================================================
	// AXI responses
	// ==========================================================
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic tx_enable;
		logic rx_enable;
		logic learn_disable;
		logic sniffer_port;
		logic rx_sniff;
		logic tx_sniff;
		logic prio_ceiling;
		logic [MEMBER_W-1:0] member;
	} hpsc_ctrl_t;

	typedef struct packed {
		logic valid;
		logic [2:0] prio;
		logic [MEMBER_W-1:0] dest;
	} hpsc_frame_t;
endpackage : hpsc_pkg

// ==== dv/test_host_port_switch_control.sv ====
/*
 * Self-checking bench for the host port switch control bank: register access
 * over AXI4-Lite, bank gating and the per-frame policy outputs.
 * Assumes hpsc_pkg and hpsc_bank are compiled first and one 50 MHz clock.
 */
`timescale 1ns/1ps
module test_host_port_switch_control;
	// ==========================================================
	// Signals
	// ==========================================================
	logic aclk;
	logic aresetn;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, tx_frame, learn_r, rx_mon_r, tx_go_r, tx_mon_r;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [2:0] default_prio;
	hpsc_pkg::hpsc_frame_t rx_frame, fwd_r;
	hpsc_pkg::hpsc_ctrl_t ctrl_r;
	logic [3:0] plain_regs [4];
	int err_total = 0;
	int tests_run = 0;

	hpsc_bank dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_frame,
		.default_prio, .tx_frame, .fwd_r, .learn_r, .rx_mon_r, .tx_go_r, .tx_mon_r, .ctrl_r);

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic tally_and_finish();
		if (err_total == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic out_of_time();
		err_total++;
		$display("[FAIL] %0t bus answer never came", $time);
		tally_and_finish();
	endtask : out_of_time

	task automatic axi_wr(input logic [3:0] idx, input logic [31:0] d, output logic [1:0] resp);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (n == 40) out_of_time();
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] idx, output logic [31:0] d, output logic [1:0] resp);
		int n;
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				resp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (n == 40) out_of_time();
	endtask : axi_rd

	// Programs control two, offers one received and one outgoing frame, checks decisions.
	task automatic frame_chk(input logic [15:0] c, input logic [2:0] p, input logic [2:0] dst,
		input logic [2:0] dp);
		logic [2:0] ep;
		axi_wr(hpsc_pkg::IDX_CONTROL_TWO, {16'h0000, c}, rs);
		ep = (c[3] && p > dp) ? dp : p;
		@(posedge aclk);
		rx_frame <= '{valid: 1'b1, prio: p, dest: dst};
		tx_frame <= 1'b1;
		default_prio <= dp;
		@(posedge aclk);
		rx_frame <= '0;
		tx_frame <= 1'b0;
		#1;
		chk(32'(fwd_r.valid), 32'(c[9]));
		if (c[9]) begin
			chk(32'(fwd_r.dest), 32'(dst & c[2:0]));
			chk(32'(fwd_r.prio), 32'(ep));
		end
		chk(32'(learn_r), 32'(c[9] & ~c[8]));
		chk(32'(rx_mon_r), 32'(c[9] & c[6]));
		chk(32'(tx_go_r), 32'(c[10]));
		chk(32'(tx_mon_r), 32'(c[10] & c[5]));
		chk(32'(ctrl_r), 32'({c[10:5], c[3:0]}));
	endtask : frame_chk

	// ==========================================================
	// Sequence
	// ==========================================================
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		rx_frame = '0;
		tx_frame = 1'b0;
		default_prio = 3'h0;
		plain_regs = '{hpsc_pkg::IDX_VID_CONTROL, hpsc_pkg::IDX_CONTROL_THREE,
			hpsc_pkg::IDX_INGRESS_RATE, hpsc_pkg::IDX_EGRESS_RATE};
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(hpsc_pkg::IDX_BANK_SELECT, rd, rs);
		chk(rd, 32'h0000_0000);
		axi_rd(hpsc_pkg::IDX_CONTROL_TWO, rd, rs);
		chk({rd[29:0], rs}, 32'(hpsc_pkg::RESP_SLVERR));
		axi_wr(hpsc_pkg::IDX_BANK_SELECT, {24'h00_0000, hpsc_pkg::BANK_HOST_PORT}, rs);
		axi_rd(hpsc_pkg::IDX_CONTROL_TWO, rd, rs);
		chk(rd, 32'h0000_0607);
		chk(32'(ctrl_r), 32'h0000_0307);
		axi_wr(hpsc_pkg::IDX_CONTROL_TWO, 32'hFFFF_FFFF, rs);
		axi_rd(hpsc_pkg::IDX_CONTROL_TWO, rd, rs);
		chk(rd, 32'h0000_67FF);
		for (int i = 0; i < 4; i++) begin
			axi_rd(plain_regs[i], rd, rs);
			chk(rd, 32'h0000_0000);
			axi_wr(plain_regs[i], 32'h5A5A_A5C3 ^ 32'(i), rs);
			axi_rd(plain_regs[i], rd, rs);
			chk({rd[29:0], rs}, {30'(16'hA5C3 ^ 16'(i)), hpsc_pkg::RESP_OKAY});
		end
		s_axi_wstrb <= 4'h1;
		axi_wr(hpsc_pkg::IDX_VID_CONTROL, 32'h0000_FFFF, rs);
		s_axi_wstrb <= 4'hF;
		axi_rd(hpsc_pkg::IDX_VID_CONTROL, rd, rs);
		chk(rd, 32'h0000_A5FF);
		frame_chk(16'h0607, 3'h5, 3'h7, 3'h2);
		frame_chk(16'h066A, 3'h6, 3'h7, 3'h3);
		frame_chk(16'h0308, 3'h3, 3'h5, 3'h3);
		frame_chk(16'h04E5, 3'h2, 3'h7, 3'h1);
		frame_chk(16'h0284, 3'h7, 3'h7, 3'h0);
		frame_chk(16'h020C, 3'h1, 3'h6, 3'h4);
		for (int b = 53; b <= 63; b++) begin
			axi_wr(hpsc_pkg::IDX_BANK_SELECT, 32'(b), rs);
			chk(32'(rs), 32'(hpsc_pkg::RESP_OKAY));
			axi_rd(hpsc_pkg::IDX_BANK_SELECT, rd, rs);
			chk(rd, 32'(b));
			axi_rd(hpsc_pkg::IDX_VID_CONTROL, rd, rs);
			chk({rd[29:0], rs}, 32'(hpsc_pkg::RESP_SLVERR));
		end
		axi_wr(hpsc_pkg::IDX_CONTROL_TWO, 32'h0000_0000, rs);
		chk(32'(rs), 32'(hpsc_pkg::RESP_SLVERR));
		axi_wr(hpsc_pkg::IDX_BANK_SELECT, {24'h00_0000, hpsc_pkg::BANK_HOST_PORT}, rs);
		axi_rd(hpsc_pkg::IDX_CONTROL_TWO, rd, rs);
		chk(rd, 32'h0000_020C);
		axi_rd(4'hC, rd, rs);
		chk({rd[29:0], rs}, 32'(hpsc_pkg::RESP_SLVERR));
		tally_and_finish();
	end
endmodule : test_host_port_switch_control
